// ===== bav_pkg.sv
// Package for the brake offset and audio-to-haptic register bank.
// Assumes one device clock; shared by the register bank and its users.
package bav_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] BAV_ADDR_BRAKE = 8'h10;
  localparam logic [7:0] BAV_ADDR_CTRL = 8'h11;
  localparam logic [7:0] BAV_ADDR_IN_FLOOR = 8'h12;
  localparam logic [7:0] BAV_ADDR_IN_FS = 8'h13;
  localparam logic [7:0] BAV_ADDR_DRV_FLOOR = 8'h14;
  localparam logic [7:0] BAV_ADDR_DRV_CEIL = 8'h15;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] BAV_RST_BRAKE = 8'h00;
  localparam logic [1:0] BAV_RST_PEAK = 2'h1;
  localparam logic [1:0] BAV_RST_LOWPASS = 2'h1;
  localparam logic [7:0] BAV_RST_IN_FLOOR = 8'h19;
  localparam logic [7:0] BAV_RST_IN_FS = 8'hFF;
  localparam logic [7:0] BAV_RST_DRV_FLOOR = 8'h19;
  localparam logic [7:0] BAV_RST_DRV_CEIL = 8'hFF;
  localparam logic [7:0] BAV_RST_CTRL = {4'h0, BAV_RST_PEAK, BAV_RST_LOWPASS};
  localparam logic signed [7:0] BAV_RST_SEARCH = 8'sh7F;

  // ****************************************
  // Field positions of the control register
  // ****************************************
  localparam int BAV_PEAK_LSB = 2;
  localparam int BAV_LOWPASS_LSB = 0;
  localparam logic [7:0] BAV_CTRL_MASK = 8'h0F;

  // ****************************************
  // Scaling and timing figures
  // ****************************************
  localparam int BAV_BRAKE_STEP_MS = 5;
  localparam int BAV_CLK_HZ = 20000000;
  localparam int BAV_BRAKE_STEP_CYC = BAV_BRAKE_STEP_MS * (BAV_CLK_HZ / 1000);
  localparam int BAV_INPUT_FS_MV = 1800;
  localparam logic [7:0] BAV_CODE_FS = 8'hFF;
  localparam logic [5:0] BAV_PEAK_MS_STEP = 6'h0A;
  localparam logic [7:0] BAV_LP_HZ0 = 8'h64;
  localparam logic [7:0] BAV_LP_HZ1 = 8'h7D;
  localparam logic [7:0] BAV_LP_HZ2 = 8'h96;
  localparam logic [7:0] BAV_LP_HZ3 = 8'hC8;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] peak_code;
    logic [5:0] peak_ms;
    logic [1:0] lowpass_code;
    logic [7:0] lowpass_hz;
  } bav_audio_cfg_t;

  typedef struct packed {
    logic valid;
    logic is_brake;
    logic [8:0] steps;
  } bav_seg_out_t;

endpackage

// ===== bav_regs.sv
// Register bank for the brake time offset and the audio-to-haptic path.
// Assumes register accesses, segment data and audio levels come from logic on mclk.
`timescale 1ns/10ps

module bav_regs (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic closed_loop,
  input wire logic wave_start,
  input wire logic scan_valid,
  input wire logic [7:0] scan_level,
  input wire logic seg_valid,
  input wire logic [7:0] seg_level,
  input wire logic [7:0] seg_steps,
  output bav_pkg::bav_seg_out_t seg_out,
  output logic [7:0] brake_time_offset,
  output bav_pkg::bav_audio_cfg_t audio_cfg,
  input wire logic audio_mode,
  input wire logic level_valid,
  input wire logic [7:0] audio_level,
  output logic drive_valid,
  output logic audio_detect,
  output logic [7:0] audio_drive
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction

  function automatic logic [7:0] sub_floor8(input logic [7:0] a, input logic [7:0] b);
    sub_floor8 = (a > b) ? a - b : 8'h00;
  endfunction

  function automatic logic [5:0] peak_win_ms(input logic [1:0] code);
    peak_win_ms = bav_pkg::BAV_PEAK_MS_STEP * ({4'h0, code} + 6'h01);
  endfunction

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction

  function automatic logic [7:0] lp_hz(input logic [1:0] code);
    unique case (code)
      2'h0: lp_hz = bav_pkg::BAV_LP_HZ0;
      2'h1: lp_hz = bav_pkg::BAV_LP_HZ1;
      2'h2: lp_hz = bav_pkg::BAV_LP_HZ2;
      2'h3: lp_hz = bav_pkg::BAV_LP_HZ3;
    endcase
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] brake_reg;
  logic [7:0] brake_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] in_floor_reg;
  logic [7:0] in_floor_next;
  logic [7:0] in_fs_reg;
  logic [7:0] in_fs_next;
  logic [7:0] drv_floor_reg;
  logic [7:0] drv_floor_next;
  logic [7:0] drv_ceil_reg;
  logic [7:0] drv_ceil_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ****************************************
  // Write decode
  // ****************************************
  wire wr_brake = reg_wr && addr_hit(reg_addr, bav_pkg::BAV_ADDR_BRAKE);
  wire wr_ctrl = reg_wr && addr_hit(reg_addr, bav_pkg::BAV_ADDR_CTRL);
  wire wr_in_floor = reg_wr && addr_hit(reg_addr, bav_pkg::BAV_ADDR_IN_FLOOR);
  wire wr_in_fs = reg_wr && addr_hit(reg_addr, bav_pkg::BAV_ADDR_IN_FS);
  wire wr_drv_floor = reg_wr && addr_hit(reg_addr, bav_pkg::BAV_ADDR_DRV_FLOOR);
  wire wr_drv_ceil = reg_wr && addr_hit(reg_addr, bav_pkg::BAV_ADDR_DRV_CEIL);

  assign brake_next = wr_brake ? reg_wdata : brake_reg;
  assign ctrl_next = wr_ctrl ? (reg_wdata & bav_pkg::BAV_CTRL_MASK) : ctrl_reg;
  assign in_floor_next = wr_in_floor ? reg_wdata : in_floor_reg;
  assign in_fs_next = wr_in_fs ? reg_wdata : in_fs_reg;
  assign drv_floor_next = wr_drv_floor ? reg_wdata : drv_floor_reg;
  assign drv_ceil_next = wr_drv_ceil ? reg_wdata : drv_ceil_reg;

  // ****************************************
  // Register storage
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      brake_reg <= bav_pkg::BAV_RST_BRAKE;
    end else begin
      brake_reg <= brake_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= bav_pkg::BAV_RST_CTRL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      in_floor_reg <= bav_pkg::BAV_RST_IN_FLOOR;
    end else begin
      in_floor_reg <= in_floor_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      in_fs_reg <= bav_pkg::BAV_RST_IN_FS;
    end else begin
      in_fs_reg <= in_fs_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      drv_floor_reg <= bav_pkg::BAV_RST_DRV_FLOOR;
    end else begin
      drv_floor_reg <= drv_floor_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      drv_ceil_reg <= bav_pkg::BAV_RST_DRV_CEIL;
    end else begin
      drv_ceil_reg <= drv_ceil_next;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      bav_pkg::BAV_ADDR_BRAKE: rdata_next = brake_reg;
      bav_pkg::BAV_ADDR_CTRL: rdata_next = ctrl_reg & bav_pkg::BAV_CTRL_MASK;
      bav_pkg::BAV_ADDR_IN_FLOOR: rdata_next = in_floor_reg;
      bav_pkg::BAV_ADDR_IN_FS: rdata_next = in_fs_reg;
      bav_pkg::BAV_ADDR_DRV_FLOOR: rdata_next = drv_floor_reg;
      bav_pkg::BAV_ADDR_DRV_CEIL: rdata_next = drv_ceil_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Output views
  // ****************************************
  assign reg_rdata = rdata_reg;
  assign brake_time_offset = brake_reg;

  // ****************************************
  // Audio configuration
  // ****************************************
  wire [1:0] peak_code = ctrl_reg[bav_pkg::BAV_PEAK_LSB +: 2];
  wire [1:0] lp_code = ctrl_reg[bav_pkg::BAV_LOWPASS_LSB +: 2];
  wire [5:0] peak_ms = peak_win_ms(peak_code);

  assign audio_cfg.peak_code = peak_code;
  assign audio_cfg.peak_ms = peak_ms;
  assign audio_cfg.lowpass_code = lp_code;
  assign audio_cfg.lowpass_hz = lp_hz(lp_code);

  // ****************************************
  // Brake segment search
  // ****************************************
  logic signed [7:0] min_level_reg;
  logic signed [7:0] min_level_next;
  logic out_valid_reg;
  logic out_brake_reg;
  logic out_brake_next;
  logic [8:0] out_steps_reg;
  logic [8:0] out_steps_next;

  wire signed [7:0] scan_s = scan_level;
  wire signed [7:0] seg_s = seg_level;
  wire scan_lower = scan_s < min_level_reg;

  assign min_level_next = wave_start ? bav_pkg::BAV_RST_SEARCH :
                          (scan_valid && scan_lower) ? scan_s : min_level_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      min_level_reg <= bav_pkg::BAV_RST_SEARCH;
    end else begin
      min_level_reg <= min_level_next;
    end
  end

  // ****************************************
  // Brake segment offset
  // ****************************************
  wire is_brake = (seg_s == min_level_reg);
  wire apply_off = is_brake && !closed_loop;
  wire signed [9:0] off_s = apply_off ? {{2{brake_reg[7]}}, brake_reg} : 10'sh000;
  wire signed [9:0] sum_s = $signed({2'h0, seg_steps}) + off_s;
  wire [8:0] sum_clip = sum_s[9] ? 9'h000 : sum_s[8:0];

  assign out_brake_next = seg_valid ? is_brake : out_brake_reg;
  assign out_steps_next = seg_valid ? sum_clip : out_steps_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_reg <= 1'b0;
      out_brake_reg <= 1'b0;
      out_steps_reg <= 9'h000;
    end else begin
      out_valid_reg <= seg_valid;
      out_brake_reg <= out_brake_next;
      out_steps_reg <= out_steps_next;
    end
  end

  assign seg_out.valid = out_valid_reg;
  assign seg_out.is_brake = out_brake_reg;
  assign seg_out.steps = out_steps_reg;

  // ****************************************
  // Audio level to drive mapping
  // ****************************************
  logic drive_valid_reg;
  logic detect_reg;
  logic detect_next;
  logic [7:0] drive_reg;
  logic [7:0] drive_next;

  wire above_floor = audio_level >= in_floor_reg;
  wire [7:0] lvl_clip = min8(audio_level, in_fs_reg);
  wire [7:0] span_in = sub_floor8(in_fs_reg, in_floor_reg);
  wire [7:0] lvl_rel = sub_floor8(lvl_clip, in_floor_reg);
  wire [15:0] lvl_prod = {8'h00, lvl_rel} * {8'h00, bav_pkg::BAV_CODE_FS};
  wire [15:0] lvl_quot = (span_in == 8'h00) ? 16'h00FF : lvl_prod / {8'h00, span_in};
  wire [7:0] raw_drive = lvl_quot[15:8] != 8'h00 ? 8'hFF : lvl_quot[7:0];
  wire [7:0] floored = max8(raw_drive, drv_floor_reg);
  wire [7:0] capped = min8(floored, drv_ceil_reg);
  wire detect_level = audio_mode && above_floor;
  wire [7:0] drive_level = detect_level ? capped : 8'h00;

  assign detect_next = level_valid ? detect_level : detect_reg;
  assign drive_next = level_valid ? drive_level : drive_reg;

  // ****************************************
  // Audio outputs
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      drive_valid_reg <= 1'b0;
    end else begin
      drive_valid_reg <= level_valid && audio_mode;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      detect_reg <= 1'b0;
      drive_reg <= 8'h00;
    end else begin
      detect_reg <= detect_next;
      drive_reg <= drive_next;
    end
  end

  assign drive_valid = drive_valid_reg;
  assign audio_detect = detect_reg;
  assign audio_drive = drive_reg;

endmodule // bav_regs

// ===== bav_regs_monitor.sv
// Checker for the brake offset and audio-to-haptic register bank.
// Assumes it is bound to bav_regs and watches only that module's ports.
`timescale 1ns/10ps
module bav_regs_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic seg_valid,
  input wire logic closed_loop,
  input wire logic [7:0] seg_steps,
  input wire bav_pkg::bav_seg_out_t seg_out,
  input wire bav_pkg::bav_audio_cfg_t audio_cfg,
  input wire logic level_valid,
  input wire logic audio_mode,
  input wire logic drive_valid,
  input wire logic audio_detect,
  input wire logic [7:0] audio_drive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ****************************************
  // Checks
  // ****************************************
  sequence s_ctrl_wr;
    reg_wr && !reg_rd && reg_addr == bav_pkg::BAV_ADDR_CTRL;
  endsequence
  sequence s_ctrl_rd;
    reg_rd && reg_addr == bav_pkg::BAV_ADDR_CTRL;
  endsequence
  a_ctrl_field_load: assert property (
    s_ctrl_wr |=> {audio_cfg.peak_code, audio_cfg.lowpass_code} == $past(reg_wdata[3:0]))
    else $error("Control fields not loaded by write.");
  a_ctrl_upper_zero: assert property (
    s_ctrl_rd |=> reg_rdata[7:4] == 4'h0)
    else $error("Reserved control bits read nonzero.");
  a_peak_decode: assert property (
    audio_cfg.peak_ms == (audio_cfg.peak_code == 2'h0 ? 6'h0A :
      audio_cfg.peak_code == 2'h1 ? 6'h14 : audio_cfg.peak_code == 2'h2 ? 6'h1E : 6'h28))
    else $error("Peak window decode wrong.");
  a_lowpass_decode: assert property (
    audio_cfg.lowpass_hz == (audio_cfg.lowpass_code == 2'h0 ? 8'h64 :
      audio_cfg.lowpass_code == 2'h1 ? 8'h7D : audio_cfg.lowpass_code == 2'h2 ? 8'h96 : 8'hC8))
    else $error("Cutoff decode wrong.");
  a_seg_answer: assert property (seg_valid |=> seg_out.valid)
    else $error("Segment result missing.");
  a_seg_no_stray: assert property (!seg_valid |=> !seg_out.valid)
    else $error("Segment result without request.");
  a_closed_no_offset: assert property (
    seg_valid && closed_loop |=> seg_out.steps == {1'h0, $past(seg_steps)})
    else $error("Offset applied in closed loop.");
  a_drive_answer: assert property (level_valid && audio_mode |=> drive_valid)
    else $error("Drive result missing.");
  a_drive_gated: assert property (!(level_valid && audio_mode) |=> !drive_valid)
    else $error("Drive result without audio request.");
  a_ignored_zero: assert property (drive_valid && !audio_detect |-> audio_drive == 8'h00)
    else $error("Ignored level still drives.");
endmodule // bav_regs_monitor
bind bav_regs bav_regs_monitor u_bav_regs_monitor (
  .mclk(mclk),
  .reset_n(reset_n),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .seg_valid(seg_valid),
  .closed_loop(closed_loop),
  .seg_steps(seg_steps),
  .seg_out(seg_out),
  .audio_cfg(audio_cfg),
  .level_valid(level_valid),
  .audio_mode(audio_mode),
  .drive_valid(drive_valid),
  .audio_detect(audio_detect),
  .audio_drive(audio_drive)
);

// ===== bav_regs_tb.sv
// Testbench for the brake offset and audio-to-haptic register bank.
// Assumes bav_pkg, bav_regs and the bound checker are compiled first.
`timescale 1ns/10ps
module bav_regs_tb;
  logic mclk = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, closed_loop = 1'h0;
  logic wave_start = 1'h0, scan_valid = 1'h0, seg_valid = 1'h0, audio_mode = 1'h0;
  logic level_valid = 1'h0, drive_valid, audio_detect;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, scan_level = 8'h00, seg_level = 8'h00;
  logic [7:0] seg_steps = 8'h00, audio_level = 8'h00, reg_rdata, brake_time_offset, audio_drive;
  bav_pkg::bav_seg_out_t seg_out;
  bav_pkg::bav_audio_cfg_t audio_cfg;
  int num_errors = 0, tests_run = 0, cyc = 0;
  logic [7:0] rv [7] = '{8'h00, 8'h05, 8'h19, 8'hFF, 8'h19, 8'hFF, 8'h00};
  logic [7:0] lp [4] = '{8'h64, 8'h7D, 8'h96, 8'hC8};
  bav_regs u_bav_regs (
    .mclk(mclk),
    .reset_n(reset_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .closed_loop(closed_loop),
    .wave_start(wave_start),
    .scan_valid(scan_valid),
    .scan_level(scan_level),
    .seg_valid(seg_valid),
    .seg_level(seg_level),
    .seg_steps(seg_steps),
    .seg_out(seg_out),
    .brake_time_offset(brake_time_offset),
    .audio_cfg(audio_cfg),
    .audio_mode(audio_mode),
    .level_valid(level_valid),
    .audio_level(audio_level),
    .drive_valid(drive_valid),
    .audio_detect(audio_detect),
    .audio_drive(audio_drive)
  );
  always #25 mclk = ~mclk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(posedge mclk);
    #1 chk(nm, {3'h0, e}, {3'h0, reg_rdata});
  endtask
  task automatic sc(input logic [7:0] l);
    @(posedge mclk);
    scan_valid <= 1'h1;
    scan_level <= l;
    @(posedge mclk);
    scan_valid <= 1'h0;
  endtask
  task automatic sg(input logic [7:0] l, input logic [7:0] s, input logic b, input logic [8:0] e);
    @(posedge mclk);
    seg_valid <= 1'h1;
    seg_level <= l;
    seg_steps <= s;
    @(posedge mclk);
    seg_valid <= 1'h0;
    #1 chk("segment", {1'h1, b, e}, seg_out);
  endtask
  task automatic au(input logic [7:0] l, input logic [7:0] e, input logic d);
    @(posedge mclk);
    level_valid <= 1'h1;
    audio_level <= l;
    @(posedge mclk);
    level_valid <= 1'h0;
    #1 chk("drive", {audio_mode, d, e}, {drive_valid, audio_detect, audio_drive});
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'h1;
    for (int i = 0; i < 7; i++) rd(8'h10 + 8'(i), rv[i], "reset");
    $display("Register reset test done");
    wr(8'h11, 8'hFF);
    rd(8'h11, 8'h0F, "control");
    for (int i = 0; i < 4; i++) begin
      wr(8'h11, {4'h0, 2'(i), 2'(3 - i)});
      chk("peak", {5'h00, 6'(10 * (i + 1))}, {5'h00, audio_cfg.peak_ms});
      chk("cutoff", {3'h0, lp[3 - i]}, {3'h0, audio_cfg.lowpass_hz});
    end
    $display("Control field test done");
    wr(8'h10, 8'hFE);
    chk("brake view", {3'h0, 8'hFE}, {3'h0, brake_time_offset});
    @(posedge mclk) wave_start <= 1'h1;
    @(posedge mclk) wave_start <= 1'h0;
    sc(8'hEC);
    sc(8'h05);
    sg(8'hEC, 8'h0A, 1'h1, 9'h008);
    sg(8'h05, 8'h0A, 1'h0, 9'h00A);
    @(posedge mclk) closed_loop <= 1'h1;
    sg(8'hEC, 8'h0A, 1'h1, 9'h00A);
    @(posedge mclk) closed_loop <= 1'h0;
    wr(8'h10, 8'h80);
    sg(8'hEC, 8'h0A, 1'h1, 9'h000);
    wr(8'h10, 8'h7F);
    sg(8'hEC, 8'hFF, 1'h1, 9'h17E);
    $display("Brake offset test done");
    @(posedge mclk) audio_mode <= 1'h1;
    au(8'hFF, 8'hFF, 1'h1);
    au(8'h10, 8'h00, 1'h0);
    au(8'h19, 8'h19, 1'h1);
    wr(8'h13, 8'h80);
    au(8'hC0, 8'hFF, 1'h1);
    wr(8'h15, 8'h80);
    au(8'hC0, 8'h80, 1'h1);
    wr(8'h14, 8'h40);
    au(8'h19, 8'h40, 1'h1);
    wr(8'h12, 8'h30);
    au(8'h2F, 8'h00, 1'h0);
    au(8'h30, 8'h40, 1'h1);
    @(posedge mclk) audio_mode <= 1'h0;
    au(8'hFF, 8'h00, 1'h0);
    $display("Audio path test done");
    @(posedge mclk) reset_n <= 1'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    #1 chk("segment after reset", 11'h000, seg_out);
    chk("drive after reset", 11'h000, {1'h0, drive_valid, audio_detect, audio_drive});
    for (int i = 0; i < 7; i++) rd(8'h10 + 8'(i), rv[i], "re-reset");
    $display("Mid-run reset test done");
    finish_test;
  end
endmodule // bav_regs_tb
